// [rtl/lvcd_params.svh]
// Register indices, field positions, reset values and timing for the dividers
`ifndef LVCD_PARAMS_SVH
`define LVCD_PARAMS_SVH

// Register indices; the byte address is four times the index
`define LVCD_IDX_A_CYC    10'h190
`define LVCD_IDX_A_CTRL   10'h191
`define LVCD_IDX_A_ROUTE  10'h192
`define LVCD_IDX_B_CYC    10'h196
`define LVCD_IDX_B_CTRL   10'h197
`define LVCD_IDX_SRC_SEL  10'h1E1

// Control register fields
`define LVCD_BIT_BYPASS   7
`define LVCD_BIT_NOSYNC   6
`define LVCD_BIT_FORCE    5
`define LVCD_BIT_START    4

// Routing register fields
`define LVCD_BIT_DIRECT   1
`define LVCD_BIT_DCC_DIS  0

// Source select codes
`define LVCD_SRC_EXT      2'h0
`define LVCD_SRC_NONE     2'h1
`define LVCD_SRC_VCO      2'h2

// Reset values
`define LVCD_RST_CYC      8'h00
`define LVCD_RST_A_CTRL   8'h80
`define LVCD_RST_B_CTRL   8'h00
`define LVCD_RST_ROUTE    2'h0
`define LVCD_RST_SRC_SEL  2'h0

// Clock period in ns at 25 MHz
`define LVCD_CLK_NS       40

`endif

// [rtl/lvcd_pkg.sv]
// Types shared by the channel divider files
package lvcd_pkg;

  // Output level of a divider, one-hot
  typedef enum logic [1:0] {
    LVCD_LVL_LOW  = 2'h1,
    LVCD_LVL_HIGH = 2'h2
  } lvcd_lvl_e;

  typedef logic [3:0] lvcd_nib_t;

endpackage

// [rtl/lvcd_div_core.sv]
// One channel divider: low/high counting, start level, phase offset, DCC
`timescale 1ns/1ns
`default_nettype none

module lvcd_div_core (
  input  wire logic            i_clk,        // System clock
  input  wire logic            i_rst_b,      // Async reset, active low
  input  wire logic            i_run,        // Counting logic powered
  input  wire logic            i_tick,       // One divider input cycle
  input  wire logic            i_sync,       // Honored sync, level
  input  wire lvcd_pkg::lvcd_nib_t i_low,    // Low cycles minus one
  input  wire lvcd_pkg::lvcd_nib_t i_high,   // High cycles minus one
  input  wire lvcd_pkg::lvcd_nib_t i_phase,  // Phase offset in cycles
  input  wire logic            i_start_high, // Start level after sync
  input  wire logic            i_dcc_en,     // Duty-cycle correction on
  output logic                 o_level       // Divided level
);

  lvcd_pkg::lvcd_lvl_e state_ff;
  logic [4:0]          cnt_ff;
  logic [5:0]          ticks_ff;
  logic                settled_ff;
  logic [8:0]          cfg_ff;
  logic                cfg_chg;
  logic                restart;
  logic                toggle;

  // Cycles minus one spent in a level; DCC gives low half the period rounded down, high the rest
  function automatic logic [4:0] dur_m1(input logic      hi,
                                        input logic [3:0] lo_f,
                                        input logic [3:0] hi_f,
                                        input logic      dcc);
    logic [5:0] total;
    logic [5:0] lo_e;
    total = {2'h0, lo_f} + {2'h0, hi_f} + 6'h02;
    lo_e  = {1'b0, total[5:1]};
    if (!dcc) begin
      dur_m1 = hi ? {1'b0, hi_f} : {1'b0, lo_f};
    end else if (hi) begin
      dur_m1 = 5'(total - lo_e - 6'h01);
    end else begin
      dur_m1 = 5'(lo_e - 6'h01);
    end
  endfunction

  assign restart = !i_run || i_sync;
  assign toggle  = i_tick && !restart && (cnt_ff == 5'h00);
  assign o_level = (state_ff == lvcd_pkg::LVCD_LVL_HIGH);

  // Level sequencer; bypass holds it idle, which stands for power-down
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= lvcd_pkg::LVCD_LVL_LOW;
      cnt_ff   <= 5'h00;
    end else if (restart) begin
      // Restart at the start level, first edge pushed out by the phase
      state_ff <= i_start_high ? lvcd_pkg::LVCD_LVL_HIGH      // [RQ9]
                               : lvcd_pkg::LVCD_LVL_LOW;
      cnt_ff   <= 5'(dur_m1(i_start_high, i_low, i_high, i_dcc_en)
                     + {1'b0, i_phase});  // [RQ17] [RQ10]
    end else if (toggle) begin
      unique case (state_ff)
        lvcd_pkg::LVCD_LVL_LOW: begin
          state_ff <= lvcd_pkg::LVCD_LVL_HIGH;
          cnt_ff   <= dur_m1(1'b1, i_low, i_high, i_dcc_en);  // [RQ2] [RQ15]
        end
        lvcd_pkg::LVCD_LVL_HIGH: begin
          state_ff <= lvcd_pkg::LVCD_LVL_LOW;
          cnt_ff   <= dur_m1(1'b0, i_low, i_high, i_dcc_en);  // [RQ1] [RQ3]
        end
      endcase
    end else if (i_tick) begin
      cnt_ff <= cnt_ff - 5'h01;                               // [RQ18]
    end
  end

  // Ticks seen in the current level; only the assertions read it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ticks_ff   <= 6'h00;
      settled_ff <= 1'b0;
    end else if (restart) begin
      ticks_ff   <= 6'h00;
      settled_ff <= 1'b0;
    end else if (toggle) begin
      ticks_ff   <= 6'h00;
      settled_ff <= 1'b1;
    end else begin
      if (i_tick) begin
        ticks_ff <= ticks_ff + 6'h01;
      end
      if (cfg_chg) begin
        settled_ff <= 1'b0;
      end
    end
  end

  // Settings of last cycle; a level begun with old counts is not measured
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_ff <= 9'h000;
    end else begin
      cfg_ff <= {i_dcc_en, i_low, i_high};
    end
  end
  assign cfg_chg = ({i_dcc_en, i_low, i_high} != cfg_ff);

  low_length_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (toggle && !o_level && settled_ff && !cfg_chg && !i_dcc_en)
      |-> ticks_ff == {2'h0, i_low})  // [RQ1]
    else $error("low level length differs from low count plus one");

  high_length_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (toggle && o_level && settled_ff && !cfg_chg && !i_dcc_en)
      |-> ticks_ff == {2'h0, i_high})  // [RQ2]
    else $error("high level length differs from high count plus one");

  zero_count_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_tick && !restart && !o_level && settled_ff && !i_dcc_en
      && i_low == 4'h0 && $stable(i_low)) |=> o_level)  // [RQ3]
    else $error("zero low count did not give a single cycle");

  sync_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_run && i_sync) |=> (o_level == $past(i_start_high)))  // [RQ9]
    else $error("level after sync is not the start level");

  phase_delay_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (restart ##1 !restart) |-> cnt_ff == 5'(dur_m1($past(i_start_high),
      $past(i_low), $past(i_high), $past(i_dcc_en))
      + {1'b0, $past(i_phase)}))  // [RQ17]
    else $error("first transition not delayed by the phase offset");

endmodule

`default_nettype wire

// [rtl/lvcd_top.sv]
// Two LVPECL channel dividers with their APB register file and routing
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "lvcd_params.svh"

// Notes on behaviour
// RQ1 - Output stays low for low count plus one input cycles.
// RQ2 - Output stays high for high count plus one input cycles.
// RQ3 - A zero count gives one cycle; both count fields reset to zero.
// RQ4 - Bypass idles the counting logic and passes the input clock through.
// RQ5 - First divider resets bypassed; second resets using its counter.
// RQ6 - Sync-ignore clear obeys chip sync; set ignores it.
// RQ7 - Software sets sync-ignore whenever it wants the force level used.
// RQ8 - Forced output is static low for force bit 0, high for 1.
// RQ9 - Start-high bit picks the level after sync; reset starts low.
// RQ10 - Four-bit phase offset per divider, reset zero, delays in cycles.
// RQ11 - Direct bit clear: both pair outputs come from the divider.
// RQ12 - Direct set with source select 10 routes oscillator to both outputs.
// RQ13 - Direct set with source select 00 routes external clock to both.
// RQ14 - Direct set with source select 01 has no effect.
// RQ15 - Correction-disable clear applies duty-cycle correction; set omits it.
// RQ16 - Second divider has same counts, bypass, sync, force in own registers.
// RQ17 - Honored sync restarts counters, applies start level, then phase delay.
// RQ18 - Period is low plus high plus two cycles, repeating continuously.
module lvcd_top (
  input  wire logic        I_CLK,                    // 25 MHz clock
  input  wire logic        I_RST_B,                  // Async reset, low
  input  wire logic        I_PSEL,                   // APB select
  input  wire logic        I_PENABLE,                // APB enable
  input  wire logic        I_PWRITE,                 // APB direction
  input  wire logic [11:0] I_PADDR,                  // APB byte address
  input  wire logic [31:0] I_PWDATA,                 // APB write data
  input  wire logic [3:0]  I_PSTRB,                  // APB byte strobes
  input  wire logic        I_VCO_CLK,                // Oscillator clock
  input  wire logic        I_EXT_CLK,                // External clock
  input  wire logic        I_SYNC,                   // Chip sync, high
  output logic [31:0]      O_PRDATA,                 // APB read data
  output logic             O_PREADY,                 // APB ready
  output logic             O_PSLVERR,                // APB error
  output logic             O_PAIR_A_OUTPUT_FIRST,    // Pair A output
  output logic             O_PAIR_A_OUTPUT_SECOND,   // Pair A output
  output logic             O_PAIR_B_OUTPUT_FIRST,    // Pair B output
  output logic             O_PAIR_B_OUTPUT_SECOND    // Pair B output
);

  logic [7:0]  a_cyc_ff;
  logic [7:0]  a_ctrl_ff;
  logic [1:0]  a_route_ff;
  logic [7:0]  b_cyc_ff;
  logic [7:0]  b_ctrl_ff;
  logic [1:0]  src_sel_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        src_ff;
  logic        src_d_ff;
  logic        tick;
  logic        div_a;
  logic        div_b;
  logic        forced_a;
  logic        forced_b;
  logic        direct_a;
  logic        nxt_out_a;
  logic        nxt_out_b;
  logic        wr_en;
  logic [9:0]  wr_idx;

  // Word index of a byte address
  function automatic logic [9:0] reg_idx(input logic [11:0] addr);
    reg_idx = addr[11:2];
  endfunction

  // Register read mux; narrow registers sit in the low bits
  function automatic logic [31:0] rd_mux(input logic [9:0] idx,
                                         input logic [7:0] ac,
                                         input logic [7:0] at,
                                         input logic [1:0] ar,
                                         input logic [7:0] bc,
                                         input logic [7:0] bt,
                                         input logic [1:0] ss);
    unique case (idx)
      `LVCD_IDX_A_CYC:   rd_mux = {24'h00_0000, ac};
      `LVCD_IDX_A_CTRL:  rd_mux = {24'h00_0000, at};
      `LVCD_IDX_A_ROUTE: rd_mux = {30'h0000_0000, ar};
      `LVCD_IDX_B_CYC:   rd_mux = {24'h00_0000, bc};
      `LVCD_IDX_B_CTRL:  rd_mux = {24'h00_0000, bt};
      `LVCD_IDX_SRC_SEL: rd_mux = {30'h0000_0000, ss};
      default:           rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // Any address outside the map answers with an error
  function automatic logic unmapped(input logic [9:0] idx);
    unmapped = !(idx == `LVCD_IDX_A_CYC  || idx == `LVCD_IDX_A_CTRL ||
                 idx == `LVCD_IDX_A_ROUTE || idx == `LVCD_IDX_B_CYC ||
                 idx == `LVCD_IDX_B_CTRL || idx == `LVCD_IDX_SRC_SEL);
  endfunction

  assign wr_idx = reg_idx(I_PADDR);
  assign wr_en  = I_PSEL && I_PENABLE && pready_ff && I_PWRITE &&
                  I_PSTRB[0] && !unmapped(wr_idx);

  // APB answer: data and ready are set up in the setup cycle so that
  // every output stays a flop; costs nothing, access phase is one cycle
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= I_PSEL && !I_PENABLE;
      pslverr_ff <= I_PSEL && !I_PENABLE && unmapped(reg_idx(I_PADDR));
      if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
        prdata_ff <= rd_mux(reg_idx(I_PADDR), a_cyc_ff, a_ctrl_ff,
                            a_route_ff, b_cyc_ff, b_ctrl_ff, src_sel_ff);
      end else begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // Divider A registers
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      a_cyc_ff   <= `LVCD_RST_CYC;                            // [RQ3]
      a_ctrl_ff  <= `LVCD_RST_A_CTRL;                         // [RQ5]
      a_route_ff <= `LVCD_RST_ROUTE;
    end else if (wr_en) begin
      if (wr_idx == `LVCD_IDX_A_CYC)   a_cyc_ff   <= I_PWDATA[7:0];
      if (wr_idx == `LVCD_IDX_A_CTRL)  a_ctrl_ff  <= I_PWDATA[7:0];
      if (wr_idx == `LVCD_IDX_A_ROUTE) a_route_ff <= I_PWDATA[1:0];
    end
  end

  // Divider B registers and the shared source select
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      b_cyc_ff   <= `LVCD_RST_CYC;                            // [RQ3]
      b_ctrl_ff  <= `LVCD_RST_B_CTRL;                         // [RQ5] [RQ16]
      src_sel_ff <= `LVCD_RST_SRC_SEL;
    end else if (wr_en) begin
      if (wr_idx == `LVCD_IDX_B_CYC)   b_cyc_ff   <= I_PWDATA[7:0];
      if (wr_idx == `LVCD_IDX_B_CTRL)  b_ctrl_ff  <= I_PWDATA[7:0];
      if (wr_idx == `LVCD_IDX_SRC_SEL) src_sel_ff <= I_PWDATA[1:0];
    end
  end

  // Distribution clock sample; a rising edge is one divider input cycle
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      src_ff   <= 1'b0;
      src_d_ff <= 1'b0;
    end else begin
      src_ff   <= (src_sel_ff == `LVCD_SRC_VCO) ? I_VCO_CLK : I_EXT_CLK;
      src_d_ff <= src_ff;
    end
  end
  assign tick = src_ff && !src_d_ff;

  // Force acts only while sync is ignored and chip sync is asserted
  assign forced_a = I_SYNC && a_ctrl_ff[`LVCD_BIT_NOSYNC];    // [RQ7]
  assign forced_b = I_SYNC && b_ctrl_ff[`LVCD_BIT_NOSYNC];    // [RQ7]
  assign direct_a = a_route_ff[`LVCD_BIT_DIRECT] &&
                    (src_sel_ff == `LVCD_SRC_VCO ||
                     src_sel_ff == `LVCD_SRC_EXT);            // [RQ14]

  lvcd_div_core u_div_a (
    .i_clk        (I_CLK),
    .i_rst_b      (I_RST_B),
    .i_run        (!a_ctrl_ff[`LVCD_BIT_BYPASS]),             // [RQ4]
    .i_tick       (tick),
    .i_sync       (I_SYNC && !a_ctrl_ff[`LVCD_BIT_NOSYNC]),   // [RQ6]
    .i_low        (a_cyc_ff[7:4]),                            // [RQ1]
    .i_high       (a_cyc_ff[3:0]),                            // [RQ2]
    .i_phase      (a_ctrl_ff[3:0]),                           // [RQ10]
    .i_start_high (a_ctrl_ff[`LVCD_BIT_START]),               // [RQ9]
    .i_dcc_en     (!a_route_ff[`LVCD_BIT_DCC_DIS]),           // [RQ15]
    .o_level      (div_a)
  );

  lvcd_div_core u_div_b (
    .i_clk        (I_CLK),
    .i_rst_b      (I_RST_B),
    .i_run        (!b_ctrl_ff[`LVCD_BIT_BYPASS]),             // [RQ16]
    .i_tick       (tick),
    .i_sync       (I_SYNC && !b_ctrl_ff[`LVCD_BIT_NOSYNC]),   // [RQ6]
    .i_low        (b_cyc_ff[7:4]),
    .i_high       (b_cyc_ff[3:0]),
    .i_phase      (b_ctrl_ff[3:0]),
    .i_start_high (b_ctrl_ff[`LVCD_BIT_START]),
    .i_dcc_en     (1'b1),
    .o_level      (div_b)
  );

  // Output selection: direct route (pair A only), then force, then bypass, then divider
  always_comb begin
    if (direct_a) begin
      nxt_out_a = src_ff;                                     // [RQ12] [RQ13]
    end else if (forced_a) begin
      nxt_out_a = a_ctrl_ff[`LVCD_BIT_FORCE];                 // [RQ8]
    end else if (a_ctrl_ff[`LVCD_BIT_BYPASS]) begin
      nxt_out_a = src_ff;                                     // [RQ4]
    end else begin
      nxt_out_a = div_a;                                      // [RQ11]
    end
    if (forced_b) begin
      nxt_out_b = b_ctrl_ff[`LVCD_BIT_FORCE];                 // [RQ16]
    end else if (b_ctrl_ff[`LVCD_BIT_BYPASS]) begin
      nxt_out_b = src_ff;
    end else begin
      nxt_out_b = div_b;
    end
  end

  // Both outputs of a pair come from one flop each, same value
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PAIR_A_OUTPUT_FIRST  <= 1'b0;
      O_PAIR_A_OUTPUT_SECOND <= 1'b0;
      O_PAIR_B_OUTPUT_FIRST  <= 1'b0;
      O_PAIR_B_OUTPUT_SECOND <= 1'b0;
    end else begin
      O_PAIR_A_OUTPUT_FIRST  <= nxt_out_a;                    // [RQ11]
      O_PAIR_A_OUTPUT_SECOND <= nxt_out_a;
      O_PAIR_B_OUTPUT_FIRST  <= nxt_out_b;
      O_PAIR_B_OUTPUT_SECOND <= nxt_out_b;
    end
  end

  assign O_PRDATA  = prdata_ff;
  assign O_PREADY  = pready_ff;
  assign O_PSLVERR = pslverr_ff;

  bypass_pass_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (a_ctrl_ff[`LVCD_BIT_BYPASS] && !direct_a && !forced_a)
      |=> O_PAIR_A_OUTPUT_FIRST == $past(src_ff))  // [RQ4]
    else $error("bypassed divider did not pass the input clock");

  reset_bypass_a: assert property (@(posedge I_CLK)
    $rose(I_RST_B) |-> a_ctrl_ff[`LVCD_BIT_BYPASS] &&
      !b_ctrl_ff[`LVCD_BIT_BYPASS] && a_cyc_ff == 8'h00)  // [RQ5]
    else $error("divider reset state is wrong");

  force_level_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (forced_b) |=> O_PAIR_B_OUTPUT_FIRST == $past(b_ctrl_ff[5]))  // [RQ8]
    else $error("forced output does not follow the force bit");

  pair_equal_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_PAIR_A_OUTPUT_FIRST == O_PAIR_A_OUTPUT_SECOND)  // [RQ11]
    else $error("pair A outputs differ");

  vco_route_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (direct_a && src_sel_ff == 2'h2 && $stable(src_sel_ff))
      |-> src_ff == $past(I_VCO_CLK) ##1 O_PAIR_A_OUTPUT_FIRST ==
      $past(src_ff))  // [RQ12]
    else $error("oscillator not routed straight to pair A");

  ext_route_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (direct_a && src_sel_ff == 2'h0 && $stable(src_sel_ff))
      |-> src_ff == $past(I_EXT_CLK))  // [RQ13]
    else $error("external clock not routed straight to pair A");

  no_effect_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (a_route_ff[1] && src_sel_ff == 2'h1 && !forced_a && !a_ctrl_ff[7])
      |=> O_PAIR_A_OUTPUT_SECOND == $past(div_a))  // [RQ14]
    else $error("direct bit acted with source select 01");

  apb_ready_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (I_PSEL && !I_PENABLE)
      |=> O_PREADY ##1 !O_PREADY || (I_PSEL && !I_PENABLE))
    else $error("APB ready not a single access cycle");

  // Forced level, pair B, direct route and bus answer checks
  force_a_level_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (forced_a && !direct_a)
      |=> O_PAIR_A_OUTPUT_FIRST == $past(a_ctrl_ff[`LVCD_BIT_FORCE]))  // [RQ8]
    else $error("forced pair A output does not follow the force bit");

  pair_b_equal_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_PAIR_B_OUTPUT_FIRST == O_PAIR_B_OUTPUT_SECOND)  // [RQ16]
    else $error("pair B outputs differ");

  bypass_b_pass_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (b_ctrl_ff[`LVCD_BIT_BYPASS] && !forced_b)
      |=> O_PAIR_B_OUTPUT_FIRST == $past(src_ff))  // [RQ4] [RQ16]
    else $error("bypassed divider B did not pass the input clock");

  ext_out_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (direct_a && src_sel_ff == `LVCD_SRC_EXT)
      |=> O_PAIR_A_OUTPUT_FIRST == $past(src_ff))  // [RQ13]
    else $error("external clock did not reach pair A output");

  slave_error_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (I_PSEL && !I_PENABLE && unmapped(reg_idx(I_PADDR)))
      |=> O_PREADY && O_PSLVERR)
    else $error("unmapped access answered without an error");

  read_idle_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !(I_PSEL && !I_PENABLE && !I_PWRITE) |=> O_PRDATA == 32'h0000_0000)
    else $error("read data not zero outside a read access");

endmodule

`default_nettype wire

// [test/lvcd_sink.sv]
// Downstream receiver model: source clocks and output run-length meter
`timescale 1ns/1ns
`default_nettype none

module lvcd_sink (
  input  wire logic       i_clk,    // System clock
  input  wire logic       i_rst_b,  // Async reset, active low
  input  wire logic       i_level,  // Watched divider output
  output logic            o_ext,    // External clock, period 2
  output logic            o_vco,    // Oscillator clock, period 4
  output logic [7:0]      o_low,    // Last complete low run, cycles
  output logic [7:0]      o_high    // Last complete high run, cycles
);
  logic       prev_ff;
  logic [7:0] run_ff;
  logic [1:0] div_ff;

  // Free-running sources so every divider always sees input cycles
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end
  assign o_ext = div_ff[0];
  assign o_vco = div_ff[1];

  // A run is recorded only when it ends, so a partial run never counts
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_ff <= 1'b0;
      run_ff  <= 8'h00;
      o_low   <= 8'h00;
      o_high  <= 8'h00;
    end else if (i_level == prev_ff) begin
      run_ff <= run_ff + 8'h01;
    end else begin
      if (prev_ff) begin
        o_high <= run_ff;
      end else begin
        o_low <= run_ff;
      end
      run_ff  <= 8'h01;
      prev_ff <= i_level;
    end
  end
endmodule

`default_nettype wire

// [test/lvpecl_channel_divider_tb.sv]
// Self-checking bench for the two channel dividers and their registers
`timescale 1ns/1ns
`default_nettype none
`include "lvcd_params.svh"

module lvpecl_channel_divider_tb;
  `define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
    mismatches++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end

  typedef struct {
    logic [7:0] cyc, ctrl;
    logic [1:0] route, src;
    logic [7:0] lo, hi;
  } lvcd_row_s;

  logic        clk = 1'b0, rst_b = 1'b0, sync = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
  logic        pready, pslverr, rerr, ext, vco;
  logic        a1, a2, b1, b2;
  logic [7:0]  lo_a, hi_a, lo_b, hi_b, hv;
  int          mismatches = 0, checks_done = 0, n0, n3;

  // Runs in system cycles: one external tick is 2, one oscillator tick 4
  lvcd_row_s rows [10] = '{
    '{8'h00, 8'h00, 2'h1, 2'h0, 8'h02, 8'h02},
    '{8'h11, 8'h00, 2'h1, 2'h0, 8'h04, 8'h04},
    '{8'h31, 8'h00, 2'h1, 2'h0, 8'h08, 8'h04},
    '{8'h0F, 8'h00, 2'h1, 2'h0, 8'h02, 8'h20},
    '{8'h30, 8'h00, 2'h0, 2'h0, 8'h04, 8'h06},
    '{8'h11, 8'h00, 2'h1, 2'h2, 8'h08, 8'h08},
    '{8'h31, 8'h00, 2'h2, 2'h2, 8'h02, 8'h02},
    '{8'h31, 8'h00, 2'h3, 2'h1, 8'h08, 8'h04},
    '{8'h00, 8'h80, 2'h1, 2'h0, 8'h01, 8'h01},
    '{8'h31, 8'h00, 2'h3, 2'h0, 8'h01, 8'h01}};

  always #(`LVCD_CLK_NS / 2) clk = ~clk;

  lvcd_top u_lvcd_top (
    .I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .I_PSTRB(4'hF), .I_VCO_CLK(vco), .I_EXT_CLK(ext), .I_SYNC(sync),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_PAIR_A_OUTPUT_FIRST(a1), .O_PAIR_A_OUTPUT_SECOND(a2),
    .O_PAIR_B_OUTPUT_FIRST(b1), .O_PAIR_B_OUTPUT_SECOND(b2));

  lvcd_sink u_lvcd_sink_a (
    .i_clk(clk), .i_rst_b(rst_b), .i_level(a1), .o_ext(ext), .o_vco(vco),
    .o_low(lo_a), .o_high(hi_a));

  lvcd_sink u_lvcd_sink_b (
    .i_clk(clk), .i_rst_b(rst_b), .i_level(b1), .o_ext(), .o_vco(),
    .o_low(lo_b), .o_high(hi_b));

  // One APB transfer; waits for ready under a bound, never a fixed count
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= 32'(wd);
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rdata   = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sync released at a fixed source phase so delays compare exactly
  task automatic sync_pulse();
    sync <= 1'b1;
    repeat (6) @(posedge clk);
    do @(posedge clk); while (ext !== 1'b1);
    sync <= 1'b0;
  endtask

  task automatic first_rise(output int n);
    sync_pulse();
    n = 0;
    while (a1 !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    // Ordinary cases: one row programs divider A and measures its runs
    foreach (rows[i]) begin
      apb(1'b1, `LVCD_IDX_SRC_SEL, 8'(rows[i].src));
      apb(1'b1, `LVCD_IDX_A_CYC, rows[i].cyc);
      apb(1'b1, `LVCD_IDX_A_CTRL, rows[i].ctrl);
      apb(1'b1, `LVCD_IDX_A_ROUTE, 8'(rows[i].route));
      sync_pulse();
      repeat (120) @(posedge clk);
      `CHK("low run", rows[i].lo, lo_a)
      `CHK("high run", rows[i].hi, hi_a)
      `CHK("pair a", a1, a2)
    end
    // Reset values after a second reset in mid-run
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, `LVCD_IDX_A_CYC, 8'h00);
    `CHK("a cycles", 32'h0000_0000, rdata)
    apb(1'b0, `LVCD_IDX_A_CTRL, 8'h00);
    `CHK("a control", 32'h0000_0080, rdata)
    apb(1'b0, `LVCD_IDX_A_ROUTE, 8'h00);
    `CHK("a routing", 32'h0000_0000, rdata)
    apb(1'b0, `LVCD_IDX_B_CYC, 8'h00);
    `CHK("b cycles", 32'h0000_0000, rdata)
    apb(1'b0, `LVCD_IDX_B_CTRL, 8'h00);
    `CHK("b control", 32'h0000_0000, rdata)
    apb(1'b0, `LVCD_IDX_SRC_SEL, 8'h00);
    `CHK("source select", 32'h0000_0000, rdata)
    // Unmapped word between the two register sets
    apb(1'b0, 10'h193, 8'h00);
    `CHK("unmapped error", 1'b1, rerr)
    `CHK("unmapped data", 32'h0000_0000, rdata)
    // Divider B in its own registers, counting and then bypassed
    apb(1'b1, `LVCD_IDX_B_CYC, 8'h22);
    apb(1'b0, `LVCD_IDX_B_CYC, 8'h00);
    `CHK("b readback", 32'h0000_0022, rdata)
    sync_pulse();
    repeat (120) @(posedge clk);
    `CHK("b low run", 8'h06, lo_b)
    `CHK("b high run", 8'h06, hi_b)
    `CHK("pair b", b1, b2)
    apb(1'b1, `LVCD_IDX_B_CTRL, 8'h80);
    repeat (40) @(posedge clk);
    `CHK("b bypass run", 8'h01, hi_b)
    // Phase offset delays the first rise by three input cycles
    apb(1'b1, `LVCD_IDX_A_ROUTE, 8'h01);
    apb(1'b1, `LVCD_IDX_A_CTRL, 8'h00);
    first_rise(n0);
    apb(1'b1, `LVCD_IDX_A_CTRL, 8'h03);
    first_rise(n3);
    `CHK("phase delay", 6, n3 - n0)
    // Held sync: forced level with sync ignored, else the start level
    for (int i = 0; i < 4; i++) begin
      hv = (i == 0) ? 8'h60 : (i == 1) ? 8'h40 : (i == 2) ? 8'h10 : 8'h00;
      apb(1'b1, `LVCD_IDX_A_CTRL, hv);
      apb(1'b1, `LVCD_IDX_B_CTRL, hv);
      sync <= 1'b1;
      repeat (20) @(posedge clk);
      `CHK("held level", (i == 0 || i == 2), a1)
      `CHK("b held level", (i == 0 || i == 2), b1)
      repeat (5) @(posedge clk);
      `CHK("held still", (i == 0 || i == 2), a1)
      sync <= 1'b0;
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
